// File: verilog/twimts_top.sv
// master transmitter sequencer of a two-wire bus with an apb register slave
// How it works
// - after start, post 08; address with write bit then goes out and ack is sampled
// - after repeated start, post 10; read bit switches to receiver (outside here)
// - address with write bit acknowledged posts 18, not acknowledged posts 20
// - data byte acknowledged posts 28, not acknowledged posts 30
// - in any ack state, done write with no requests sends next data byte
// - done write with begin only sends repeated start, data register untouched
// - done write with halt only sends stop and clears halt bit itself
// - done write with both sends stop then start, halt bit self-clears
// - arbitration lost during address or data posts 38 and raises done flag
// - in 38, done write with no requests releases bus, not-addressed slave
// - in 38, done write with begin waits for bus free then sends start
// - when addressed after arbitration loss in the address byte, post 68, 78 or b0
// - any number of data bytes may follow the address phase
// - misplaced start or stop posts 00; halt plus done write releases lines silently
// - while done flag is clear, status reads f8
`timescale 1ns/1ns
`default_nettype none
`include "twimts_defines.svh"
module twimts_top #(
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq
);
  if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div_w
    $error("twimts_top: DIV_W out of range");
  end

  // pin synchronisers, two flops each
  logic [1:0] scl_sync_q, sda_sync_q;
  logic scl_prev_q, sda_prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end
  wire logic scl_s = scl_sync_q[1];
  wire logic sda_s = sda_sync_q[1];
  twimts_pkg::twimts_cond_type cond;
  assign cond.start_seen = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign cond.stop_seen = scl_s && scl_prev_q && !sda_prev_q && sda_s;
  wire logic scl_rise = scl_s && !scl_prev_q;

  // registers
  twimts_pkg::twimts_state_type state_q;
  logic done_q, acken_q, begin_q, halt_q, en_q, busy_bus_q;
  logic [7:0] status_q, data_q, shift_q;
  logic [6:0] own_addr_q;
  logic [7:0] bitdiv_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic [2:0] bit_q;
  logic [3:0] irq_stat_q, irq_mask_q;
  logic in_frame_q, sa_act_q, addr_phase_q;
  logic [7:0] rx_shift_q;
  logic [3:0] rx_cnt_q;
  twimts_pkg::twimts_drive_type drv_q;

  // apb decode, zero wait states
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic wr_ctrl = wr && paddr == `TWIMTS_OFF_CTRL;
  wire logic wr_data = wr && paddr == `TWIMTS_OFF_DATA;
  wire logic wr_istat = wr && paddr == `TWIMTS_OFF_IRQ_STAT;
  wire logic wr_imask = wr && paddr == `TWIMTS_OFF_IRQ_MASK;
  wire logic wr_own = wr && paddr == `TWIMTS_OFF_OWN_ADDR;
  wire logic wr_div = wr && paddr == `TWIMTS_OFF_BITDIV;
  wire logic addr_ok = paddr == `TWIMTS_OFF_CTRL || paddr == `TWIMTS_OFF_STATUS
    || paddr == `TWIMTS_OFF_DATA || paddr == `TWIMTS_OFF_IRQ_STAT
    || paddr == `TWIMTS_OFF_IRQ_MASK || paddr == `TWIMTS_OFF_OWN_ADDR
    || paddr == `TWIMTS_OFF_BITDIV;
  wire logic go = wr_ctrl && pwdata[`TWIMTS_CTRL_DONE] && done_q;
  wire logic go_begin = pwdata[`TWIMTS_CTRL_BEGIN];
  wire logic go_halt = pwdata[`TWIMTS_CTRL_HALT];
  wire logic [7:0] ctrl_rd = {done_q, acken_q, begin_q, halt_q, 1'b0, en_q, 2'h0};
  wire logic [7:0] status_rd = done_q ? status_q : `TWIMTS_ST_IDLE;
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      `TWIMTS_OFF_CTRL: rd_mux = {24'h000000, ctrl_rd};
      `TWIMTS_OFF_STATUS: rd_mux = {24'h000000, status_rd};
      `TWIMTS_OFF_DATA: rd_mux = {24'h000000, data_q};
      `TWIMTS_OFF_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_q};
      `TWIMTS_OFF_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_q};
      `TWIMTS_OFF_OWN_ADDR: rd_mux = {25'h0000000, own_addr_q};
      `TWIMTS_OFF_BITDIV: rd_mux = {24'h000000, bitdiv_q};
      default: rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // quarter-bit tick from the divider
  wire logic tick = div_cnt_q == DIV_W'(0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= tick ? DIV_W'(bitdiv_q) : div_cnt_q - DIV_W'(1);
    end
  end

  // bus-activity tracker: frame position for bus error and bus-free detect
  // a repeated start or stop rides the first clock of a byte, so that one is legal
  wire logic bit_pos_mid = in_frame_q && rx_cnt_q > 4'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_bus_q <= 1'b0;
      in_frame_q <= 1'b0;
      rx_cnt_q <= 4'h0;
      rx_shift_q <= 8'h00;
    end else begin
      if (cond.start_seen) begin
        busy_bus_q <= 1'b1;
        in_frame_q <= 1'b1;
        rx_cnt_q <= 4'h0;
      end else if (cond.stop_seen) begin
        busy_bus_q <= 1'b0;
        in_frame_q <= 1'b0;
        rx_cnt_q <= 4'h0;
      end else if (scl_rise && in_frame_q) begin
        rx_shift_q <= {rx_shift_q[6:0], sda_s};
        rx_cnt_q <= rx_cnt_q == 4'h8 ? 4'h0 : rx_cnt_q + 4'h1;
      end
    end
  end
  // own address seen after arbitration loss, 9th clock (ack slot)
  wire logic addr_done = scl_rise && rx_cnt_q == 4'h8 && addr_phase_q;
  wire logic gc_hit = rx_shift_q[7:1] == 7'h00;
  wire logic own_hit = rx_shift_q[7:1] == own_addr_q && acken_q;
  wire logic bus_err = (cond.start_seen || cond.stop_seen) && bit_pos_mid
    && state_q != twimts_pkg::S_STOP_C && state_q != twimts_pkg::S_START_B;

  // sequencer
  logic post;
  logic [7:0] post_code;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= twimts_pkg::S_IDLE;
      done_q <= 1'b0;
      status_q <= `TWIMTS_ST_IDLE;
      acken_q <= 1'b0;
      begin_q <= 1'b0;
      halt_q <= 1'b0;
      en_q <= 1'b0;
      data_q <= 8'h00;
      shift_q <= 8'h00;
      bit_q <= 3'h0;
      drv_q <= '0;
      sa_act_q <= 1'b0;
      addr_phase_q <= 1'b0;
      own_addr_q <= `TWIMTS_OWN_RESET;
      bitdiv_q <= `TWIMTS_BITDIV_RESET;
      post <= 1'b0;
      post_code <= 8'h00;
    end else begin
      post <= 1'b0;
      if (wr_own) own_addr_q <= pwdata[6:0];
      if (wr_div) bitdiv_q <= pwdata[7:0];
      if (wr_data && done_q) data_q <= pwdata[7:0];
      if (wr_ctrl) begin
        acken_q <= pwdata[`TWIMTS_CTRL_ACKEN];
        en_q <= pwdata[`TWIMTS_CTRL_EN];
        begin_q <= go_begin;
        halt_q <= go_halt;
      end
      if (go) done_q <= 1'b0;
      if (bus_err) begin
        state_q <= twimts_pkg::S_HOLD;
        done_q <= 1'b1;
        status_q <= `TWIMTS_ST_BUS_ERR;
      end else if (go && status_q == `TWIMTS_ST_BUS_ERR && go_halt) begin
        drv_q <= '0;
        halt_q <= 1'b0;
        state_q <= twimts_pkg::S_SLAVE;
      end else if (go && status_q == `TWIMTS_ST_ARB_LOST) begin
        drv_q <= '0;
        sa_act_q <= 1'b0;
        state_q <= go_begin ? twimts_pkg::S_WAIT_FREE : twimts_pkg::S_SLAVE;
      end else if (go && (status_q == `TWIMTS_ST_START || status_q == `TWIMTS_ST_RSTART
          || status_q == `TWIMTS_ST_AW_ACK || status_q == `TWIMTS_ST_AW_NACK
          || status_q == `TWIMTS_ST_D_ACK || status_q == `TWIMTS_ST_D_NACK)) begin
        if (go_halt) begin
          halt_q <= 1'b0;
          state_q <= twimts_pkg::S_STOP_A;
        end else if (go_begin && status_q != `TWIMTS_ST_START && status_q != `TWIMTS_ST_RSTART) begin
          state_q <= twimts_pkg::S_START_A;
        end else begin
          shift_q <= wr_data ? pwdata[7:0] : data_q;
          addr_phase_q <= status_q == `TWIMTS_ST_START || status_q == `TWIMTS_ST_RSTART;
          bit_q <= 3'h7;
          state_q <= twimts_pkg::S_BIT_LOW;
        end
      end else if (wr_ctrl && go_begin && !done_q && state_q == twimts_pkg::S_IDLE && pwdata[`TWIMTS_CTRL_EN]) begin
        state_q <= twimts_pkg::S_WAIT_FREE;
      end else if (tick) begin
        case (state_q)
          twimts_pkg::S_WAIT_FREE: if (!busy_bus_q && scl_s && sda_s) state_q <= twimts_pkg::S_START_A;
          twimts_pkg::S_START_A: begin
            drv_q <= '0; // release both before a start
            state_q <= twimts_pkg::S_START_B;
          end
          twimts_pkg::S_START_B: begin
            drv_q.sda_oe <= 1'b1;
            state_q <= twimts_pkg::S_HOLD;
            post <= 1'b1;
            post_code <= status_q == `TWIMTS_ST_IDLE || status_q == `TWIMTS_ST_ARB_LOST
              || status_q == `TWIMTS_ST_BUS_ERR || !in_frame_q ? `TWIMTS_ST_START : `TWIMTS_ST_RSTART;
          end
          twimts_pkg::S_HOLD: drv_q.scl_oe <= 1'b1; // stretch clock while waiting for software
          twimts_pkg::S_BIT_LOW: begin
            drv_q.scl_oe <= 1'b1; // data moves only a tick after the clock went low
            if (drv_q.scl_oe) begin
              drv_q.sda_oe <= !shift_q[bit_q];
              state_q <= twimts_pkg::S_BIT_HIGH;
            end
          end
          twimts_pkg::S_BIT_HIGH: begin
            drv_q.scl_oe <= 1'b0; // sample only once the release is seen through the synchroniser
            if (scl_s && !drv_q.scl_oe) begin
              if (shift_q[bit_q] && !sda_s) begin
                drv_q <= '0;
                state_q <= twimts_pkg::S_IDLE;
                sa_act_q <= 1'b1;
                post <= 1'b1;
                post_code <= `TWIMTS_ST_ARB_LOST;
              end else begin
                bit_q <= bit_q - 3'h1;
                state_q <= bit_q == 3'h0 ? twimts_pkg::S_ACK_LOW : twimts_pkg::S_BIT_LOW;
              end
            end
          end
          twimts_pkg::S_ACK_LOW: begin
            drv_q.scl_oe <= 1'b1;
            if (drv_q.scl_oe) begin
              drv_q.sda_oe <= 1'b0; // hand the data line to the slave
              state_q <= twimts_pkg::S_ACK_HIGH;
            end
          end
          twimts_pkg::S_ACK_HIGH: begin
            drv_q.scl_oe <= 1'b0;
            if (scl_s && !drv_q.scl_oe) begin
              state_q <= twimts_pkg::S_HOLD;
              post <= 1'b1;
              if (addr_phase_q) post_code <= sda_s ? `TWIMTS_ST_AW_NACK : `TWIMTS_ST_AW_ACK;
              else post_code <= sda_s ? `TWIMTS_ST_D_NACK : `TWIMTS_ST_D_ACK;
            end
          end
          twimts_pkg::S_STOP_A: begin
            drv_q <= '{scl_oe: 1'b1, sda_oe: 1'b1};
            state_q <= twimts_pkg::S_STOP_B;
          end
          twimts_pkg::S_STOP_B: begin
            drv_q.scl_oe <= 1'b0;
            state_q <= twimts_pkg::S_STOP_C;
          end
          twimts_pkg::S_STOP_C: begin
            drv_q.sda_oe <= 1'b0;
            state_q <= begin_q ? twimts_pkg::S_WAIT_FREE : twimts_pkg::S_IDLE;
          end
          default: ;
        endcase
      end
      // slave hand-off after lost arbitration
      if (sa_act_q && addr_done && (own_hit || (gc_hit && acken_q))) begin
        sa_act_q <= 1'b0;
        post <= 1'b1;
        post_code <= rx_shift_q[0] ? `TWIMTS_ST_SLV_TX : (gc_hit ? `TWIMTS_ST_SLV_GC : `TWIMTS_ST_SLV_RX);
      end
      if (post) begin
        done_q <= 1'b1;
        status_q <= post_code;
      end
    end
  end

  // sticky interrupt status, write one to clear, set wins
  wire logic [3:0] ev = {bus_err, post && post_code == `TWIMTS_ST_ARB_LOST,
    state_q == twimts_pkg::S_STOP_C && tick, post};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 4'h0;
      irq_mask_q <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_istat ? pwdata[3:0] : 4'h0)) | ev;
      if (wr_imask) irq_mask_q <= pwdata[3:0];
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // pins: open drain, drive low only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe <= drv_q.scl_oe;
      sda_oe <= drv_q.sda_oe;
    end
  end
endmodule : twimts_top
`default_nettype wire

// File: include/twimts_defines.svh
// constants for the two-wire master transmit sequencer
`ifndef TWIMTS_DEFINES_SVH
`define TWIMTS_DEFINES_SVH
`define TWIMTS_ST_START      8'h08
`define TWIMTS_ST_RSTART     8'h10
`define TWIMTS_ST_AW_ACK     8'h18
`define TWIMTS_ST_AW_NACK    8'h20
`define TWIMTS_ST_D_ACK      8'h28
`define TWIMTS_ST_D_NACK     8'h30
`define TWIMTS_ST_ARB_LOST   8'h38
`define TWIMTS_ST_SLV_RX     8'h68
`define TWIMTS_ST_SLV_GC     8'h78
`define TWIMTS_ST_SLV_TX     8'hB0
`define TWIMTS_ST_BUS_ERR    8'h00
`define TWIMTS_ST_IDLE       8'hF8
`define TWIMTS_OFF_CTRL      12'h000
`define TWIMTS_OFF_STATUS    12'h004
`define TWIMTS_OFF_DATA      12'h008
`define TWIMTS_OFF_IRQ_STAT  12'h00C
`define TWIMTS_OFF_IRQ_MASK  12'h010
`define TWIMTS_OFF_OWN_ADDR  12'h014
`define TWIMTS_OFF_BITDIV    12'h018
`define TWIMTS_CTRL_DONE     7
`define TWIMTS_CTRL_ACKEN    6
`define TWIMTS_CTRL_BEGIN    5
`define TWIMTS_CTRL_HALT     4
`define TWIMTS_CTRL_EN       2
`define TWIMTS_BITDIV_RESET  8'h0A
`define TWIMTS_OWN_RESET     7'h00
`endif

// File: include/twimts_pkg.sv
// types for the two-wire master transmit sequencer
package twimts_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_WAIT_FREE, S_START_A, S_START_B, S_HOLD, S_BIT_LOW, S_BIT_HIGH,
    S_ACK_LOW, S_ACK_HIGH, S_STOP_A, S_STOP_B, S_STOP_C, S_SLAVE
  } twimts_state_type;
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } twimts_drive_type;
  typedef struct packed {
    logic start_seen;
    logic stop_seen;
  } twimts_cond_type;
endpackage : twimts_pkg

// File: tb/twimts_top_asserts.sv
// port checker for the two-wire master transmit sequencer
`timescale 1ns/1ns
`default_nettype none
module twimts_top_asserts #(
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // register bus answer timing
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_zero_wait: assert property (psel && !penable |=> pready) else $error("no zero-wait answer");
  a_ready_access: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
  // address decoding
  a_unmapped_err: assert property (pready && paddr > 12'h018 |-> pslverr) else $error("unmapped accepted");
  a_mapped_ok: assert property (pready && !pwrite && paddr <= 12'h018 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped read refused");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside read");
  // open drain outputs never drive high
  a_open_drain: assert property (!scl_out && !sda_out) else $error("line driven high");
endmodule : twimts_top_asserts
bind twimts_top twimts_top_asserts #(.DIV_W(DIV_W)) twimts_top_asserts_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
`default_nettype wire

// File: tb/twimts_slave_model.sv
// behavioural slave receiver on the two-wire bus
`timescale 1ns/1ns
`default_nettype none
module twimts_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  output logic sda_oe,
  output logic [7:0] rx_byte
);
  int bit_n;
  logic [7:0] sh;
  initial begin
    bit_n = 0;
    sda_oe = 1'b0;
    rx_byte = 8'h00;
  end
  // start or repeated start opens a new frame
  always @(negedge sda) if (scl) begin
    bit_n = 0;
    sda_oe <= 1'b0;
  end
  // bits sampled on rising clock, msb first, any number of bytes
  always @(posedge scl) begin
    if (bit_n < 8) sh = {sh[6:0], sda};
    bit_n++;
  end
  // acknowledge slot driven after the eighth bit
  always @(negedge scl) begin
    if (bit_n == 8) begin
      rx_byte <= sh;
      sda_oe <= !nack;
    end else if (bit_n == 9) begin
      sda_oe <= 1'b0;
      bit_n = 0;
    end
  end
endmodule : twimts_slave_model
`default_nettype wire

// File: tb/tb_twi_master_transmit_sequencer.sv
// self-checking bench for the two-wire master transmit sequencer
`timescale 1ns/1ns
`default_nettype none
`include "twimts_defines.svh"
module tb_twi_master_transmit_sequencer;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, err_q, slv_oe;
  logic nack = 1'b0;
  logic [7:0] rx_byte;
  wire scl_w;
  wire sda_w;
  int bad_count = 0;
  int checks = 0;
  // pulled-up open drain lines
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe || slv_oe);
  initial forever #50 pclk = !pclk;
  twimts_top twimts_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  twimts_slave_model twimts_slave_model_i (.scl(scl_w), .sda(sda_w), .nack(nack), .sda_oe(slv_oe),
    .rx_byte(rx_byte));
  task final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer, result left in rd and err_q
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      final_report();
    end
  endtask : xfer
  // bounded wait for a register bit
  task poll(input logic [11:0] a, input int b);
    int n;
    n = 0;
    do begin
      xfer(a, 1'b0, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 400);
    if (rd[b] !== 1'b1) begin
      bad_count++;
      final_report();
    end
  endtask : poll
  // control write, then wait for the posted code
  task go(input logic [31:0] ctl, input logic [31:0] exp);
    xfer(`TWIMTS_OFF_CTRL, 1'b1, ctl);
    xfer(`TWIMTS_OFF_STATUS, 1'b0, 32'h0);
    check(rd, 32'hF8);
    poll(`TWIMTS_OFF_CTRL, 7);
    xfer(`TWIMTS_OFF_STATUS, 1'b0, 32'h0);
    check(rd, exp);
  endtask : go
  // byte out with no requests, checked at the slave
  task send(input logic [7:0] d, input logic [31:0] exp);
    xfer(`TWIMTS_OFF_DATA, 1'b1, {24'h0, d});
    go(32'h84, exp);
    check({24'h0, rx_byte}, {24'h0, d});
  endtask : send
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(`TWIMTS_OFF_STATUS, 1'b0, 32'h0);
    check(rd, 32'hF8);
    xfer(12'h01C, 1'b0, 32'h0);
    check({31'h0, err_q}, 32'h1);
    xfer(`TWIMTS_OFF_BITDIV, 1'b1, 32'h1);
    xfer(`TWIMTS_OFF_IRQ_MASK, 1'b1, 32'h0);
    go(32'h24, 32'h08);
    check({31'h0, irq}, 32'h0);
    xfer(`TWIMTS_OFF_IRQ_MASK, 1'b1, 32'h1);
    xfer(`TWIMTS_OFF_IRQ_STAT, 1'b0, 32'h0);
    check({31'h0, rd[0]}, 32'h1);
    check({31'h0, irq}, 32'h1);
    xfer(`TWIMTS_OFF_IRQ_MASK, 1'b1, 32'h0);
    xfer(`TWIMTS_OFF_IRQ_STAT, 1'b1, 32'h1);
    xfer(`TWIMTS_OFF_IRQ_STAT, 1'b0, 32'h0);
    check({31'h0, rd[0]}, 32'h0);
    check({31'h0, irq}, 32'h0);
    send(8'hC8, 32'h18);
    send(8'h33, 32'h28);
    send(8'h55, 32'h28);
    nack <= 1'b1;
    send(8'h44, 32'h30);
    go(32'hA4, 32'h10);
    xfer(`TWIMTS_OFF_DATA, 1'b0, 32'h0);
    check(rd, 32'h44);
    send(8'hC8, 32'h20);
    nack <= 1'b0;
    send(8'h12, 32'h28);
    go(32'hB4, 32'h08);
    xfer(`TWIMTS_OFF_CTRL, 1'b0, 32'h0);
    check({31'h0, rd[4]}, 32'h0);
    send(8'hC8, 32'h18);
    xfer(`TWIMTS_OFF_IRQ_STAT, 1'b1, 32'hF);
    xfer(`TWIMTS_OFF_CTRL, 1'b1, 32'h94);
    poll(`TWIMTS_OFF_IRQ_STAT, 1);
    xfer(`TWIMTS_OFF_CTRL, 1'b0, 32'h0);
    check({31'h0, rd[4]}, 32'h0);
    xfer(`TWIMTS_OFF_STATUS, 1'b0, 32'h0);
    check(rd, 32'hF8);
    final_report();
  end
endmodule : tb_twi_master_transmit_sequencer
`default_nettype wire
